// file: common/plor_defines.svh
// Offsets, field positions, reset values and timing counts of the indicator
// override and transceiver control block.
// Assumes a 20 MHz APB clock and 32-bit APB data.
`ifndef PLOR_DEFINES_SVH
`define PLOR_DEFINES_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define PLOR_IDX_INDICATOR_OVERRIDE 8'h18
`define PLOR_IDX_TRANSCEIVER_CONTROL 8'h19
`define PLOR_IDX_INT_STATUS 8'h20
`define PLOR_IDX_INT_MASK 8'h21
`define PLOR_ADDR_W 10

// ****************************************************************
// Indicator override fields.
// ****************************************************************
`define PLOR_OVR_SPEED_EN 5
`define PLOR_OVR_LINK_EN 4
`define PLOR_OVR_ACT_EN 3
`define PLOR_OVR_SPEED_VAL 2
`define PLOR_OVR_LINK_VAL 1
`define PLOR_OVR_ACT_VAL 0
`define PLOR_OVR_W 6
`define PLOR_OVR_RESET 6'h00

// ****************************************************************
// Transceiver control fields.
// ****************************************************************
`define PLOR_TC_AUTO_XOVER 15
`define PLOR_TC_XOVER_FORCE 14
`define PLOR_TC_PAUSE_RX 13
`define PLOR_TC_PAUSE_TX 12
`define PLOR_TC_ERR_INJECT 11
`define PLOR_TC_LONG_SEQ 10
`define PLOR_TC_PASS 9
`define PLOR_TC_RUN 8
`define PLOR_TC_STRETCH_BYP 7

// Pause field positions inside the two-bit advertisement slice.
`define PLOR_ADV_PAUSE 0
`define PLOR_ADV_ASYM 1

// ****************************************************************
// Interrupt status and mask fields.
// ****************************************************************
`define PLOR_INT_W 2
`define PLOR_INT_SELFTEST_FAIL 0
`define PLOR_INT_PAUSE_CHANGE 1
`define PLOR_INT_RESET 2'h0

// ****************************************************************
// Timing.
// ****************************************************************
`define PLOR_CLK_PERIOD_NS 50
`define PLOR_STRETCH_TIME_NS 1000
`define PLOR_STRETCH_CYCLES \
  ((`PLOR_STRETCH_TIME_NS + `PLOR_CLK_PERIOD_NS - 1) / `PLOR_CLK_PERIOD_NS)
`define PLOR_STRETCH_W 5

`endif

// file: common/plor_pkg.sv
// Types shared by the indicator override and transceiver control block.
// Assumes plor_defines.svh is on the include path.
package plor_pkg;

  // Three indicator lines travel together.
  typedef struct packed {
    logic speed;
    logic link;
    logic activity;
  } plor_ind_s;

  // Pause resolution result.
  typedef struct packed {
    logic rx;
    logic tx;
  } plor_pause_s;

  // Self-test controls handed to the self-test engine.
  typedef struct packed {
    logic run;
    logic long_seq;
    logic error_inject;
  } plor_selftest_s;

endpackage

// file: rtl/plor_top.sv
// APB register bank for indicator override and transceiver control.
// Assumes all inputs are synchronous to pclk and the engines are outside.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "plor_defines.svh"

// What this block does
// - Bits 15 to 6 of the indicator override register ignore writes and read as zero.
// - With override bit 5 set the speed indicator shows stored bit 2, else its normal source.
// - With override bit 4 set the link indicator shows stored bit 1, else its normal source.
// - With override bit 3 set the activity indicator shows stored bit 0, else its normal source.
// - Reading the override register returns stored bits, never the live pin levels.
// - Control bit 15 enables automatic crossover and resets to the strap value.
// - Control bit 14 forces the media pairs crossed.
// - Read-only bit 13 reports pause receive from both pause advertisements.
// - Read-only bit 12 reports pause transmit from both pause advertisements.
// - Pause bits are set only for a full duplex common mode, per the pause resolution table.
// - Writing one to bit 11 injects exactly one self-test error and the bit clears itself.
// - Self test runs while bit 8 is one; bit 10 picks the long sequence when one.
// - Bit 9 reads one for pass, a fail is latched and clears only when self test stops.
// - Bit 7 bypasses indicator pulse stretching.
module plor_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire plor_pkg::plor_ind_s indicator_status,
  output plor_pkg::plor_ind_s indicator_pins,
  input wire logic auto_crossover_strap,
  output logic auto_crossover_enable,
  output logic crossover_force,
  input wire logic [1:0] local_adv_pause,
  input wire logic [1:0] partner_pause,
  input wire logic hcd_full_duplex,
  output plor_pkg::plor_pause_s pause_result,
  output plor_pkg::plor_selftest_s selftest_ctrl,
  input wire logic selftest_error,
  output logic irq
);

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  logic access;
  logic wr_commit;
  logic [7:0] idx;
  logic sel_ovr;
  logic sel_tc;
  logic sel_ist;
  logic sel_imk;
  logic mapped;

  assign access = psel & penable;
  assign wr_commit = access & pready & pwrite;
  assign idx = paddr[`PLOR_ADDR_W-1:2];
  assign sel_ovr = (paddr[1:0] == 2'h0) && (idx == `PLOR_IDX_INDICATOR_OVERRIDE);
  assign sel_tc = (paddr[1:0] == 2'h0) && (idx == `PLOR_IDX_TRANSCEIVER_CONTROL);
  assign sel_ist = (paddr[1:0] == 2'h0) && (idx == `PLOR_IDX_INT_STATUS);
  assign sel_imk = (paddr[1:0] == 2'h0) && (idx == `PLOR_IDX_INT_MASK);
  assign mapped = (paddr[31:`PLOR_ADDR_W] == '0) && (sel_ovr | sel_tc | sel_ist | sel_imk);

  // ****************************************************************
  // Stored register state.
  // ****************************************************************
  logic [`PLOR_OVR_W-1:0] ovr_reg;
  logic auto_xover_reg;
  logic strap_taken_reg;
  logic xover_force_reg;
  logic inject_reg;
  logic long_seq_reg;
  logic run_reg;
  logic bypass_reg;
  logic fail_reg;
  plor_pkg::plor_pause_s pause_reg;
  plor_pkg::plor_pause_s pause_next;
  logic [`PLOR_INT_W-1:0] int_status_reg;
  logic [`PLOR_INT_W-1:0] int_mask_reg;
  logic [`PLOR_INT_W-1:0] int_event;

  // Only the low six bits are stored; the rest of the word is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_reg <= `PLOR_OVR_RESET;
    end else if (wr_commit && sel_ovr) begin
      ovr_reg <= pwdata[`PLOR_OVR_W-1:0];
    end
  end

  // The strap is caught at the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_xover_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      auto_xover_reg <= auto_crossover_strap;
      strap_taken_reg <= 1'b1;
    end else if (wr_commit && sel_tc) begin
      auto_xover_reg <= pwdata[`PLOR_TC_AUTO_XOVER];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xover_force_reg <= 1'b0;
      long_seq_reg <= 1'b0;
      run_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (wr_commit && sel_tc) begin
      xover_force_reg <= pwdata[`PLOR_TC_XOVER_FORCE];
      long_seq_reg <= pwdata[`PLOR_TC_LONG_SEQ];
      run_reg <= pwdata[`PLOR_TC_RUN];
      bypass_reg <= pwdata[`PLOR_TC_STRETCH_BYP];
    end
  end

  // A written one lives exactly one cycle and then clears itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inject_reg <= 1'b0;
    end else begin
      inject_reg <= wr_commit & sel_tc & pwdata[`PLOR_TC_ERR_INJECT];
    end
  end

  // ****************************************************************
  // Self-test pass flag.
  // ****************************************************************
  // A fail seen while running is held until the run bit is cleared.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_reg <= 1'b0;
    end else if (!run_reg) begin
      fail_reg <= 1'b0;
    end else if (selftest_error) begin
      fail_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Pause resolution.
  // ****************************************************************
  always_comb begin
    pause_next = '0;
    if (hcd_full_duplex) begin
      if (local_adv_pause[`PLOR_ADV_PAUSE] && partner_pause[`PLOR_ADV_PAUSE]) begin
        pause_next.rx = 1'b1;
        pause_next.tx = 1'b1;
      end else if (!local_adv_pause[`PLOR_ADV_PAUSE] && local_adv_pause[`PLOR_ADV_ASYM] &&
                   partner_pause[`PLOR_ADV_PAUSE] && partner_pause[`PLOR_ADV_ASYM]) begin
        pause_next.tx = 1'b1;
      end else if (local_adv_pause[`PLOR_ADV_PAUSE] && local_adv_pause[`PLOR_ADV_ASYM] &&
                   !partner_pause[`PLOR_ADV_PAUSE] && partner_pause[`PLOR_ADV_ASYM]) begin
        pause_next.rx = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_reg <= '0;
    end else begin
      pause_reg <= pause_next;
    end
  end

  // ****************************************************************
  // Interrupts.
  // ****************************************************************
  assign int_event[`PLOR_INT_SELFTEST_FAIL] = run_reg & selftest_error & ~fail_reg;
  assign int_event[`PLOR_INT_PAUSE_CHANGE] = (pause_next != pause_reg);

  // Writing one clears a bit, but an event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= `PLOR_INT_RESET;
    end else if (wr_commit && sel_ist) begin
      int_status_reg <= (int_status_reg & ~pwdata[`PLOR_INT_W-1:0]) | int_event;
    end else begin
      int_status_reg <= int_status_reg | int_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= `PLOR_INT_RESET;
    end else if (wr_commit && sel_imk) begin
      int_mask_reg <= pwdata[`PLOR_INT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_reg & int_mask_reg);
    end
  end

  // ****************************************************************
  // Indicator stretching and override.
  // ****************************************************************
  logic [2:0] raw_status;
  logic [2:0] stretched;
  logic [2:0] ovr_en;
  logic [2:0] ovr_val;

  assign raw_status = indicator_status;
  assign ovr_en = {ovr_reg[`PLOR_OVR_SPEED_EN], ovr_reg[`PLOR_OVR_LINK_EN],
                   ovr_reg[`PLOR_OVR_ACT_EN]};
  assign ovr_val = {ovr_reg[`PLOR_OVR_SPEED_VAL], ovr_reg[`PLOR_OVR_LINK_VAL],
                    ovr_reg[`PLOR_OVR_ACT_VAL]};

  // Each line is held on for a minimum time after its source drops.
  for (genvar i = 0; i < 3; i++) begin : g_stretch
    logic [`PLOR_STRETCH_W-1:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= '0;
      end else if (raw_status[i]) begin
        cnt_reg <= `PLOR_STRETCH_W'(`PLOR_STRETCH_CYCLES);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - `PLOR_STRETCH_W'(1);
      end
    end
    assign stretched[i] = bypass_reg ? raw_status[i] : (raw_status[i] | (cnt_reg != '0));
  end

  // Registered pins give a clean switch between override and source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_pins <= '0;
    end else begin
      indicator_pins.speed <= ovr_en[2] ? ovr_val[2] : stretched[2];
      indicator_pins.link <= ovr_en[1] ? ovr_val[1] : stretched[1];
      indicator_pins.activity <= ovr_en[0] ? ovr_val[0] : stretched[0];
    end
  end

  // ****************************************************************
  // Control outputs.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_crossover_enable <= 1'b0;
      crossover_force <= 1'b0;
      pause_result <= '0;
      selftest_ctrl <= '0;
    end else begin
      auto_crossover_enable <= auto_xover_reg;
      crossover_force <= xover_force_reg;
      pause_result <= pause_reg;
      selftest_ctrl.run <= run_reg;
      selftest_ctrl.long_seq <= long_seq_reg;
      selftest_ctrl.error_inject <= inject_reg;
    end
  end

  // ****************************************************************
  // Read path and bus answer.
  // ****************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (sel_ovr) begin
      rd_word[`PLOR_OVR_W-1:0] = ovr_reg;
    end else if (sel_tc) begin
      rd_word[`PLOR_TC_AUTO_XOVER] = auto_xover_reg;
      rd_word[`PLOR_TC_XOVER_FORCE] = xover_force_reg;
      rd_word[`PLOR_TC_PAUSE_RX] = pause_reg.rx;
      rd_word[`PLOR_TC_PAUSE_TX] = pause_reg.tx;
      rd_word[`PLOR_TC_ERR_INJECT] = inject_reg;
      rd_word[`PLOR_TC_LONG_SEQ] = long_seq_reg;
      rd_word[`PLOR_TC_PASS] = run_reg & ~fail_reg;
      rd_word[`PLOR_TC_RUN] = run_reg;
      rd_word[`PLOR_TC_STRETCH_BYP] = bypass_reg;
    end else if (sel_ist) begin
      rd_word[`PLOR_INT_W-1:0] = int_status_reg;
    end else if (sel_imk) begin
      rd_word[`PLOR_INT_W-1:0] = int_mask_reg;
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

endmodule

// file: verif/plor_checker.sv
// Port assertions for the indicator override and transceiver control bank.
// Assumes it is bound into plor_top with every port name unchanged.
`timescale 1ns/1ps
module plor_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire plor_pkg::plor_ind_s indicator_pins,
  input wire logic crossover_force,
  input wire logic [1:0] local_adv_pause,
  input wire logic [1:0] partner_pause,
  input wire logic hcd_full_duplex,
  input wire plor_pkg::plor_pause_s pause_result,
  input wire plor_pkg::plor_selftest_s selftest_ctrl
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  function automatic logic [1:0] pz(logic [1:0] l, logic [1:0] p, logic h);
    if (!h) return 2'h0;
    if (l[0] && p[0]) return 2'h3;
    if (l == 2'h2 && p == 2'h3) return 2'h1;
    if (l == 2'h3 && p == 2'h2) return 2'h2;
    return 2'h0;
  endfunction
  access_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  unmapped_err_a: assert property (acc && !(paddr inside {32'h60, 32'h64, 32'h80, 32'h84})
    |-> pslverr) else $error("unmapped address accepted");
  ovr_reserved_a: assert property (acc && !pwrite && paddr == 32'h60 |->
    prdata[31:6] == 26'h0) else $error("reserved bits not zero");
  pause_result_a: assert property ($past(presetn, 2) |-> pause_result == pz(
    $past(local_adv_pause, 2), $past(partner_pause, 2), $past(hcd_full_duplex, 2)))
    else $error("pause result wrong");
  inject_pulse_a: assert property (selftest_ctrl.error_inject |=>
    !selftest_ctrl.error_inject) else $error("inject longer than one cycle");
  inject_write_a: assert property (wr && paddr == 32'h64 && pwdata[11]
    |-> ##[1:3] selftest_ctrl.error_inject) else $error("inject missing");
  ctl_follow_a: assert property (wr && paddr == 32'h64 |-> ##2
    {crossover_force, selftest_ctrl.long_seq, selftest_ctrl.run} ==
    $past({pwdata[14], pwdata[10], pwdata[8]}, 2)) else $error("control outputs wrong");
  ovr_pins_a: assert property (wr && paddr == 32'h60 |-> ##2
    ($past(pwdata[5:3], 2) & indicator_pins) ==
    ($past(pwdata[5:3], 2) & $past(pwdata[2:0], 2))) else $error("override not on pins");
  ovr_write_c: cover property (wr && paddr == 32'h60);
  pause_both_c: cover property (pause_result == 2'h3);
  inject_c: cover property (selftest_ctrl.error_inject);
endmodule
bind plor_top plor_checker plor_checker_inst (.*);

// file: verif/plor_selftest_model.sv
// Behavioural self-test engine that answers an injected error.
// Assumes the controls come straight from plor_top.
`timescale 1ns/1ps
module plor_selftest_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire plor_pkg::plor_selftest_s selftest_ctrl,
  output logic selftest_error
);
  // ****************************************************************
  // Error report
  // ****************************************************************
  // An injected error is seen one cycle later, only while running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) selftest_error <= 1'b0;
    else selftest_error <= selftest_ctrl.run && selftest_ctrl.error_inject;
  end
endmodule

// file: verif/plor_top_bench.sv
// Self-checking bench for the indicator override and transceiver control bank.
// Assumes plor_top, plor_selftest_model and the checker are compiled alongside.
`timescale 1ns/1ps
module plor_top_bench;
  // ****************************************************************
  // Signals, tasks and model
  // ****************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, ovr_m;
  logic pready, pslverr, err, auto_crossover_enable, crossover_force, irq, selftest_error;
  logic auto_crossover_strap = 1;
  logic hcd_full_duplex = 0;
  logic [1:0] local_adv_pause = 0, partner_pause = 0;
  logic [32'h1f:0] seed = 32'h0000b5e1;
  plor_pkg::plor_ind_s indicator_status = 0, indicator_pins;
  plor_pkg::plor_pause_s pause_result;
  plor_pkg::plor_selftest_s selftest_ctrl;
  int fails = 0, samples_checked = 0, cyc = 0, inj = 0;
  plor_top plor_top_inst (.*);
  plor_selftest_model plor_selftest_model_inst (.*);
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (selftest_ctrl.error_inject === 1'b1) inj++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int pz(int l, int p, int h);
    if (h == 0) return 0;
    if (l % 2 == 1 && p % 2 == 1) return 3;
    return (l == 2 && p == 3) ? 1 : ((l == 3 && p == 2) ? 2 : 0);
  endfunction
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    apb(0, 32'h60, 0);
    check("override reset", rd, 0);
    apb(0, 32'h64, 0);
    check("control reset", rd, 32'h8000);
    check("crossover enable", auto_crossover_enable, 1);
    apb(1, 32'h64, 32'h8080);
    for (int i = 0; i < 8; i++) begin
      ovr_m = xs();
      indicator_status <= 3'(xs());
      apb(1, 32'h60, ovr_m);
      apb(0, 32'h60, 0);
      check("override read", rd, ovr_m & 32'h3f);
      check("pins", indicator_pins,
            3'((ovr_m >> 3) & ovr_m | ~(ovr_m >> 3) & indicator_status));
    end
    indicator_status <= 0;
    apb(1, 32'h60, 0);
    apb(1, 32'h64, 32'h8000);
    repeat (22) @(posedge pclk);
    indicator_status <= 3'h7;
    @(posedge pclk);
    indicator_status <= 3'h0;
    // Pins stay on 20 cycles past the source, plus one for the output register.
    repeat (21) @(posedge pclk);
    check("stretched", indicator_pins, 3'h7);
    @(posedge pclk);
    check("stretch end", indicator_pins, 3'h0);
    $display("test indicators done");
    for (int i = 0; i < 32; i++) begin
      {hcd_full_duplex, local_adv_pause, partner_pause} <= 5'(i);
      repeat (4) @(posedge pclk);
      apb(0, 32'h64, 0);
      check("pause read", rd, 32'h8000 | pz(i / 4 % 4, i % 4, i / 16) << 12);
      check("pause pins", pause_result, pz(i / 4 % 4, i % 4, i / 16));
    end
    {hcd_full_duplex, local_adv_pause, partner_pause} <= 5'h0;
    $display("test pause done");
    apb(1, 32'h84, 1);
    apb(1, 32'h64, 32'h8500);
    repeat (4) @(posedge pclk);
    apb(0, 32'h64, 0);
    check("self test pass", rd, 32'h8700);
    check("self test ctrl", selftest_ctrl, 3'h6);
    apb(1, 32'h64, 32'h8d00);
    repeat (6) @(posedge pclk);
    apb(0, 32'h64, 0);
    check("self test fail", rd, 32'h8500);
    check("inject count", inj, 1);
    check("irq raised", irq, 1);
    apb(1, 32'h84, 0);
    apb(0, 32'h80, 0);
    check("int status", rd, 3);
    check("irq masked", irq, 0);
    apb(1, 32'h80, 3);
    apb(1, 32'h84, 1);
    apb(0, 32'h80, 0);
    check("int cleared", rd, 0);
    check("irq cleared", irq, 0);
    apb(1, 32'h64, 32'h8400);
    apb(0, 32'h64, 0);
    check("self test stopped", rd, 32'h8400);
    apb(1, 32'h64, 32'h8100);
    repeat (4) @(posedge pclk);
    apb(0, 32'h64, 0);
    check("self test rerun", rd, 32'h8300);
    $display("test self test done");
    apb(1, 32'h64, 32'h4000);
    apb(0, 32'h70, 0);
    check("unmapped error", err, 1);
    check("unmapped data", rd, 0);
    check("crossover force", {auto_crossover_enable, crossover_force}, 2'h1);
    $display("test crossover done");
    conclude();
  end
endmodule
